//--- tb_tid_decode.sv
// Bench for instruction decode, scan paths and drive selection.
// Assumes the tester model sits beside the block on the same i_clk.
`timescale 1ns/1ps
`include "tid_params.svh"
module tb_tid_decode;
  localparam int BL = `TID_BSC_LEN;
  logic          i_clk, i_rst_n, o_tdo, o_tdo_en_n, smp, bit_o, e, d;
  logic          tck, tdi;
  logic [6:0]    st;
  logic [BL-1:0] i_pin_in, i_core_out, o_pin_out, o_core_in;
  logic [1:0]    i_dbg, o_dbg;
  logic [2:0]    o_instr, md;
  logic          q[$];
  logic          tv[0:159];
  int            cs[5] = '{111, 112, 122, 123, 124};
  int            fails, checks, len, seed;

  tid_tester tid_tester_i (.i_clk(i_clk), .i_tdo(o_tdo), .o_tck(tck), .o_tdi(tdi),
    .o_st(st), .o_smp(smp), .o_bit(bit_o));
  tid_decode tid_decode_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tdi(tdi),
    .i_capture_ir(st[5]), .i_shift_ir(st[4]), .i_update_ir(st[3]),
    .i_capture_dr(st[2]), .i_shift_dr(st[1]), .i_update_dr(st[0]),
    .i_tap_reset(st[6]), .i_pin_in(i_pin_in), .i_core_out(i_core_out),
    .i_debug_control_inputs(i_dbg), .o_tdo(o_tdo), .o_tdo_en_n(o_tdo_en_n),
    .o_pin_out(o_pin_out), .o_core_in(o_core_in),
    .o_debug_control_inputs(o_dbg), .o_instr(o_instr));

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Chain position (0 nearest tdo) to cell index for the current path
  function automatic int idx(int p);
    if (md == 3'h2) return (p < `TID_CLK_CELL - 1) ? p : p + 1;
    if (md == 3'h6) return cs[p];
    return p;
  endfunction
  function automatic logic ex(int k);
    if (k >= len) return tv[k - len];
    if (len == 1) return 1'b0;
    // The control/status subset captures pin OR core, the wide paths pin XOR core
    if (md == 3'h6) return i_pin_in[idx(k)] | i_core_out[idx(k)];
    return i_pin_in[idx(k)] ^ i_core_out[idx(k)];
  endfunction
  task automatic ir(input logic [2:0] c);
    tid_tester_i.step(7'h20, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      q.push_back(k == 0);
      tid_tester_i.step(7'h10, c[k], 1'b1);
    end
    chk(o_tdo_en_n === 1'b0, "tdo enable while shifting");
    tid_tester_i.step(7'h08, 1'b0, 1'b0);
    tid_tester_i.step(7'h00, 1'b0, 1'b0);
  endtask
  task automatic dr;
    tid_tester_i.step(7'h04, 1'b0, 1'b0);
    for (int k = 0; k < len + 8; k++) begin
      q.push_back(ex(k));
      tid_tester_i.step(7'h02, tv[k], 1'b1);
    end
    tid_tester_i.step(7'h01, 1'b0, 1'b0);
    tid_tester_i.step(7'h00, 1'b0, 1'b0);
  endtask

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // About seven times the expected length of the run
  initial begin
    #1000000;
    fails++;
    give_verdict();
  end
  always @(posedge i_clk) begin
    if (smp === 1'b1) begin
      chk(bit_o === q[0], "serial out");
      d = q.pop_front();
    end
  end

  initial begin
    seed = 73722;
    i_rst_n = 1'b0;
    i_pin_in = BL'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
    i_core_out = BL'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
    i_dbg = 2'($random(seed));
    repeat (5) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    chk(o_instr === 3'h7 && o_tdo_en_n === 1'b1 && o_tdo === 1'b0, "reset state");
    // Let the synchronisers settle before the first test clock edge
    repeat (3) @(posedge i_clk);
    // Intest is run with the memory clock taken as an input
    for (int c = 7; c >= 0; c--) begin
      md = c[2:0];
      for (int k = 0; k < 160; k++) tv[k] = 1'($random(seed));
      ir(md);
      chk(o_instr === md && o_tdo_en_n === 1'b1, "instruction");
      if (md == 3'h2) len = BL - 1;
      else if (md == 3'h6) len = `TID_CS_LEN;
      else if (md inside {3'h1, 3'h3, 3'h7}) len = 1;
      else len = BL;
      dr();
      if (md inside {3'h0, 3'h2, 3'h4}) begin
        for (int p = 0; p < len; p++) begin
          e = tv[p + 8];
          chk(o_pin_out[idx(p)] === e, "hold to pin");
          chk(o_core_in[idx(p)] === e, "hold to core");
          if (idx(p) inside {111, 112}) chk(o_dbg[idx(p) - 111] === e, "hold to debug");
        end
      end else if (md == 3'h6)
        chk(o_dbg === {tv[9], tv[8]} && o_pin_out === i_core_out, "debug");
      else
        chk(o_pin_out === i_core_out && o_core_in === i_pin_in && o_dbg === i_dbg, "normal");
    end
    tid_tester_i.step(7'h40, 1'b0, 1'b0);
    tid_tester_i.step(7'h00, 1'b0, 1'b0);
    chk(o_instr === 3'h7, "tap reset");
    give_verdict();
  end
endmodule

//--- tid_decode.sv
// Test access port instruction register, decode and serial path selection.
// Assumes TAP controller state strobes come from logic on i_clk; the test
// clock and serial data arrive from pins and are synchronised here.
// How it works
// - Three-bit instruction register, bit 0 nearest output
// - Reserved code acts exactly as bypass
// - Extest: pins and core inputs from hold
// - Intest: outputs held, core inputs from hold
// - Sample: normal operation, boundary captured
// - Control scan: only the five subset cells shift, two drive debug
// - No-clock-cell extest omits memory clock cell
// - Bypass: single register, processor unaffected
// - Instruction capture loads fixed 001
// - Bypass bit captures zero, no effect
// - Five serial paths chosen by state and instruction
// - Control scan shifts no other cell
// - Shift/update on system clock, edge-aligned
// - Main chain 141 cells, five enable cells
`timescale 1ns/1ps
`include "tid_params.svh"
module tid_decode #(
  parameter int BSC_LEN = `TID_BSC_LEN
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // Test pins, asynchronous
  input  wire logic                 i_tck,
  input  wire logic                 i_tdi,
  // TAP controller state strobes
  input  wire logic                 i_capture_ir,
  input  wire logic                 i_shift_ir,
  input  wire logic                 i_update_ir,
  input  wire logic                 i_capture_dr,
  input  wire logic                 i_shift_dr,
  input  wire logic                 i_update_dr,
  input  wire logic                 i_tap_reset,
  // System side
  input  wire logic [BSC_LEN-1:0]   i_pin_in,
  input  wire logic [BSC_LEN-1:0]   i_core_out,
  input  wire logic [`TID_DC_W-1:0] i_debug_control_inputs,
  // Outputs
  output logic                      o_tdo,
  output logic                      o_tdo_en_n,
  output logic [BSC_LEN-1:0]        o_pin_out,
  output logic [BSC_LEN-1:0]        o_core_in,
  output logic [`TID_DC_W-1:0]      o_debug_control_inputs,
  output logic [2:0]                o_instr
);
  localparam int CS_LEN = `TID_CS_LEN;
  localparam int CC     = `TID_CLK_CELL - 1;

  // Control/status subset cell positions in the main chain (0-based)
  localparam int CS_POS [CS_LEN] = '{111, 112, 122, 123, 124};

  // Pin synchronisers
  logic [1:0] tck_s_r, tck_s_nxt, tdi_s_r, tdi_s_nxt;
  logic       tck_d_r, tck_d_nxt;
  logic       rise, fall;

  logic [2:0]          ir_sh_r, ir_sh_nxt, ir_r, ir_nxt;
  logic                byp_r, byp_nxt;
  logic [BSC_LEN-1:0]  chain_r, chain_nxt, hold_r, hold_nxt;
  logic                tdo_r, tdo_nxt, tdo_en_n_r, tdo_en_n_nxt;
  logic [BSC_LEN-1:0]  pin_out_r, pin_out_nxt, core_in_r, core_in_nxt;
  logic [`TID_DC_W-1:0] dc_r, dc_nxt;

  tid_pkg::tid_instr_t ins;
  tid_pkg::tid_path_t  path;
  logic                hold_out, hold_core, hold_dc, cap_core;

  function automatic tid_pkg::tid_instr_t canon(input logic [2:0] c);
    // Reserved and preload codes fold onto bypass
    if (c == 3'h3 || c == 3'h1) canon = tid_pkg::TID_BYPASS;
    else canon = tid_pkg::tid_instr_t'(c);
  endfunction

  always_comb begin
    ins       = canon(ir_r);
    hold_out  = 1'b0;
    hold_core = 1'b0;
    hold_dc   = 1'b0;
    cap_core  = 1'b1;
    case (ins)
      tid_pkg::TID_EXTEST, tid_pkg::TID_EXT_NCC: begin
        hold_out  = 1'b1;
        hold_core = 1'b1;
      end
      tid_pkg::TID_INTEST: begin
        hold_out  = 1'b1;
        hold_core = 1'b1;
      end
      tid_pkg::TID_SAMPLE: cap_core = 1'b1;
      tid_pkg::TID_CSSCAN: hold_dc = 1'b1;
      default: cap_core = 1'b1;
    endcase
  end

  always_comb begin
    if (i_shift_ir || i_capture_ir) path = tid_pkg::TID_P_IR;
    else case (ins)
      tid_pkg::TID_EXTEST, tid_pkg::TID_INTEST, tid_pkg::TID_SAMPLE: path = tid_pkg::TID_P_MAIN;
      tid_pkg::TID_CSSCAN:  path = tid_pkg::TID_P_CS;
      tid_pkg::TID_EXT_NCC: path = tid_pkg::TID_P_NCC;
      default:              path = tid_pkg::TID_P_BYP;
    endcase
  end

  always_comb begin
    tck_s_nxt    = {tck_s_r[0], i_tck};
    tdi_s_nxt    = {tdi_s_r[0], i_tdi};
    tck_d_nxt    = tck_s_r[1];
    rise         = tck_s_r[1] & ~tck_d_r;
    fall         = ~tck_s_r[1] & tck_d_r;
    ir_sh_nxt    = ir_sh_r;
    ir_nxt       = ir_r;
    byp_nxt      = byp_r;
    chain_nxt    = chain_r;
    hold_nxt     = hold_r;
    tdo_nxt      = tdo_r;
    tdo_en_n_nxt = tdo_en_n_r;
    if (rise) begin
      // sampling on the test clock's rising edge
      if (i_capture_ir) ir_sh_nxt = `TID_IR_CAPTURE;
      else if (i_shift_ir) ir_sh_nxt = {tdi_s_r[1], ir_sh_r[2:1]};
      if (i_update_ir) ir_nxt = ir_sh_r;
      if (i_capture_dr) begin
        byp_nxt = `TID_BYP_CAPTURE;
        if (path == tid_pkg::TID_P_CS) begin
          for (int k = 0; k < CS_LEN; k++)
            chain_nxt[CS_POS[k]] = cap_core ? i_core_out[CS_POS[k]] | i_pin_in[CS_POS[k]]
                                            : i_pin_in[CS_POS[k]];
        end else if (path != tid_pkg::TID_P_BYP) begin
          chain_nxt = i_pin_in ^ i_core_out;
        end
      end else if (i_shift_dr) begin
        case (path)
          tid_pkg::TID_P_MAIN: chain_nxt = {tdi_s_r[1], chain_r[BSC_LEN-1:1]};
          tid_pkg::TID_P_NCC: begin
            for (int k = 0; k < BSC_LEN - 1; k++)
              if (k != CC && k != CC - 1) chain_nxt[k] = chain_r[k + 1];
            chain_nxt[CC - 1]  = chain_r[CC + 1];
            chain_nxt[BSC_LEN-1] = tdi_s_r[1];
          end
          tid_pkg::TID_P_CS: begin
            for (int k = 0; k < CS_LEN - 1; k++) chain_nxt[CS_POS[k]] = chain_r[CS_POS[k+1]];
            chain_nxt[CS_POS[CS_LEN-1]] = tdi_s_r[1];
          end
          default: byp_nxt = tdi_s_r[1];
        endcase
      end
      if (i_update_dr && path != tid_pkg::TID_P_BYP) hold_nxt = chain_r;
    end
    if (fall) begin
      // output changes on the falling edge
      tdo_en_n_nxt = ~(i_shift_ir | i_shift_dr);
      case (path)
        tid_pkg::TID_P_IR:  tdo_nxt = ir_sh_r[0];
        tid_pkg::TID_P_BYP: tdo_nxt = byp_r;
        tid_pkg::TID_P_CS:  tdo_nxt = chain_r[CS_POS[0]];
        default:            tdo_nxt = chain_r[0];
      endcase
    end
    if (i_tap_reset) ir_nxt = `TID_IR_RESET;
  end

  always_comb begin
    pin_out_nxt = hold_out ? hold_r : i_core_out;
    core_in_nxt = hold_core ? hold_r : i_pin_in;
    dc_nxt      = (hold_core || hold_dc) ? {hold_r[CS_POS[1]], hold_r[CS_POS[0]]}
                                         : i_debug_control_inputs;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tck_s_r    <= 2'h0;
      tdi_s_r    <= 2'h0;
      tck_d_r    <= 1'h0;
      ir_sh_r    <= `TID_IR_CAPTURE;
      ir_r       <= `TID_IR_RESET;
      byp_r      <= 1'h0;
      chain_r    <= '0;
      hold_r     <= '0;
      tdo_r      <= 1'h0;
      tdo_en_n_r <= 1'h1;
      pin_out_r  <= '0;
      core_in_r  <= '0;
      dc_r       <= '0;
    end else begin
      tck_s_r    <= tck_s_nxt;
      tdi_s_r    <= tdi_s_nxt;
      tck_d_r    <= tck_d_nxt;
      ir_sh_r    <= ir_sh_nxt;
      ir_r       <= ir_nxt;
      byp_r      <= byp_nxt;
      chain_r    <= chain_nxt;
      hold_r     <= hold_nxt;
      tdo_r      <= tdo_nxt;
      tdo_en_n_r <= tdo_en_n_nxt;
      pin_out_r  <= pin_out_nxt;
      core_in_r  <= core_in_nxt;
      dc_r       <= dc_nxt;
    end
  end

  assign o_tdo                  = tdo_r;
  assign o_tdo_en_n             = tdo_en_n_r;
  assign o_pin_out              = pin_out_r;
  assign o_core_in              = core_in_r;
  assign o_debug_control_inputs = dc_r;
  assign o_instr                = ir_r;

  a_ir_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise && i_capture_ir) |=> ir_sh_r == 3'h1) else $error("capture not 001");
  a_ir_shift: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise && i_shift_ir && !i_capture_ir) |=> ir_sh_r[2] == $past(tdi_s_r[1])
      && ir_sh_r[1:0] == $past(ir_sh_r[2:1])) else $error("ir shift order wrong");
  a_byp_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise && i_capture_dr) |=> !byp_r) else $error("bypass capture not 0");
  a_rsvd_bypass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == 3'h3 && !i_shift_ir && !i_capture_ir) |-> path == tid_pkg::TID_P_BYP)
    else $error("reserved not bypass");
  a_ext_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == 3'h0) |=> o_pin_out == $past(hold_r)) else $error("extest pins not held");
  a_int_core: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == 3'h4) |=> o_core_in == $past(hold_r)) else $error("intest core not held");
  a_samp_norm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == 3'h5) |=> o_pin_out == $past(i_core_out)) else $error("sample disturbs pins");
  a_byp_norm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ir_r == 3'h7) |=> o_core_in == $past(i_pin_in)) else $error("bypass disturbs core");
  a_cs_only: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise && i_shift_dr && !i_capture_dr && path == tid_pkg::TID_P_CS)
      |=> chain_r[0] == $past(chain_r[0])) else $error("non-subset cell shifted");
  a_ncc_skip: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rise && i_shift_dr && !i_capture_dr && path == tid_pkg::TID_P_NCC)
      |=> chain_r[CC] == $past(chain_r[CC])) else $error("clock cell shifted");
  a_tdo_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !fall |=> o_tdo == $past(o_tdo)) else $error("tdo changed off falling edge");
endmodule

//--- tid_params.svh
// Constants for the test-port instruction decode block.
// Assumes inclusion by the package, the design file and the bench.
`ifndef TID_PARAMS_SVH
`define TID_PARAMS_SVH
`define TID_IR_W        3
`define TID_IR_CAPTURE  3'h1
`define TID_IR_RESET    3'h7
`define TID_BYP_CAPTURE 1'h0
`define TID_BSC_LEN     141
`define TID_CS_LEN      5
`define TID_CLK_CELL    110
`define TID_DC_W        2
`define TID_SYNC_STAGES 2
`endif

//--- tid_pkg.sv
// Types for the test-port instruction decode block.
// Assumes tid_params.svh sits in the same folder.
`include "tid_params.svh"
package tid_pkg;
  typedef enum logic [2:0] {
    TID_EXTEST  = 3'h0,
    TID_PRELOAD = 3'h1,
    TID_EXT_NCC = 3'h2,
    TID_RSVD    = 3'h3,
    TID_INTEST  = 3'h4,
    TID_SAMPLE  = 3'h5,
    TID_CSSCAN  = 3'h6,
    TID_BYPASS  = 3'h7
  } tid_instr_t;
  typedef enum logic [4:0] {
    TID_P_IR   = 5'h01,
    TID_P_BYP  = 5'h02,
    TID_P_MAIN = 5'h04,
    TID_P_CS   = 5'h08,
    TID_P_NCC  = 5'h10
  } tid_path_t;
endpackage

//--- tid_tester.sv
// Board tester model: test clock, serial data and TAP state strobes.
// Assumes one test clock spans 8 i_clk cycles and tdo settles within 3.
`timescale 1ns/1ps
module tid_tester (
  // Clock and serial return
  input  wire logic       i_clk,
  input  wire logic       i_tdo,
  // Test pins and state strobes
  output logic            o_tck,
  output logic            o_tdi,
  output logic [6:0]      o_st,
  // Sampled serial return
  output logic            o_smp,
  output logic            o_bit
);
  initial begin
    {o_tck, o_tdi, o_st, o_smp, o_bit} = '0;
  end
  // One test clock; return is sampled just before the clock rises
  task automatic step(input logic [6:0] s, input logic d, input logic m);
    @(posedge i_clk);
    #1;
    o_bit = i_tdo;
    o_smp = m;
    o_st  = s;
    // Idle data line carries no stale value
    o_tdi = (s == 7'h00) ? ~o_tdi : d;
    o_tck = 1'b1;
    @(posedge i_clk);
    #1;
    o_smp = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    o_tck = 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule
